// ==== hw/dram_burst_core.sv ====
// bank precharge tracking, burst select engine, read fifo and link output stage
`timescale 1ns/1ps

module dram_word_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_fill_valid,
    output logic                  o_fill_ready,
    input  wire logic [WIDTH-1:0] i_fill_data,
    output logic                  o_drain_valid,
    input  wire logic             i_drain_ready,
    output logic [WIDTH-1:0]      o_drain_data
);
    localparam int PB = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PB-1:0]               wr;
        logic [PB-1:0]               rd;
        logic [PB:0]                 count;
    } fifo_type;
    fifo_type s;
    fifo_type next_s;
    logic     push;
    logic     pop;

    // full and empty come straight from the count
    assign o_fill_ready  = (s.count != (PB+1)'(DEPTH));
    assign o_drain_valid = (s.count != '0);
    assign o_drain_data  = s.mem[s.rd];
    assign push          = i_fill_valid && o_fill_ready;
    assign pop           = o_drain_valid && i_drain_ready;

    // pointers wrap at the depth, which need not be a power of two
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr] = i_fill_data;
            next_s.wr = (s.wr == PB'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = (s.rd == PB'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
        end
        next_s.count = s.count + (PB+1)'(push) - (PB+1)'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // dram_word_fifo

// Operation
// - a precharge closes the open row of the addressed bank, or of every bank when the all form is used.
// - while a bank auto-precharges, a read or write to another bank is taken without cutting a transfer.
// - a precharge to an idle or already precharging bank is taken and is never an error.
// - the precharge period of a bank is timed from the latest precharge to it.
// - with a burst field of 01, the burst select address bit picks a chopped four-beat burst when low and a full eight-beat burst when high.
// - the burst select address bit is never part of the column address.
// - a full burst results from a burst field of 00, or of 01 with the burst select address bit high.
// - auto precharge may be asked for or not with either burst length.
// - a write beat with broken setup or hold may corrupt only its own location; all else runs on. Here the violation flag inverts both beats of its word.
// - an activated row stays open until a precharge to its bank, and only then may another row open.
module dram_burst_core (
    input  wire logic                                 i_clk,
    input  wire logic                                 i_rst,
    input  wire logic                                 i_link_clk,
    input  wire logic                                 i_cmd_valid,
    input  wire logic [2:0]                           i_cmd,
    input  wire logic [dram_burst_pkg::BANK_BITS-1:0] i_bank,
    input  wire logic [dram_burst_pkg::ADDR_BITS-1:0] i_addr,
    input  wire logic [1:0]                           i_mode_burst_field,
    input  wire logic [4:0]                           i_additive_latency,
    input  wire logic [4:0]                           i_cas_latency,
    input  wire logic                                 i_wdata_valid,
    input  wire logic [dram_burst_pkg::WORD_BITS-1:0] i_wdata,
    input  wire logic                                 i_wdata_violation,
    output logic                                      o_write_ready,
    output logic                                      o_cmd_refused,
    output logic [dram_burst_pkg::NUM_BANKS-1:0]      o_bank_open,
    output logic [dram_burst_pkg::NUM_BANKS-1:0]      o_bank_precharging,
    output logic [dram_burst_pkg::WORD_BITS-1:0]      o_link_data,
    output logic                                      o_link_strobe_oe,
    output logic                                      o_link_last
);
    typedef struct packed {
        dram_burst_pkg::phase_type                                              phase;
        logic [dram_burst_pkg::NUM_BANKS-1:0]                                   open;
        logic [dram_burst_pkg::NUM_BANKS-1:0]                                   pre_busy;
        logic [dram_burst_pkg::NUM_BANKS-1:0][dram_burst_pkg::PRE_BITS-1:0]     pre_cnt;
        logic [dram_burst_pkg::BANK_BITS-1:0]                                   bank;
        logic [dram_burst_pkg::COLUMN_BITS-1:0]                                 column;
        logic                                                                   full;
        logic                                                                   auto_pre;
        logic [1:0]                                                             word;
        logic [dram_burst_pkg::LAT_BITS-1:0]                                    lat;
        logic [dram_burst_pkg::LAT_BITS-1:0]                                    rl;
        logic                                                                   refused;
        logic [dram_burst_pkg::MEM_WORDS-1:0][dram_burst_pkg::BEAT_BITS-1:0]    mem;
        logic [dram_burst_pkg::LINK_BITS-1:0]                                   xfer;
        logic                                                                   req_tog;
        logic                                                                   ack_meta;
        logic                                                                   ack_sync;
    } core_type;

    typedef struct packed {
        logic                                 rst_meta;
        logic                                 rst_sync;
        logic                                 req_meta;
        logic                                 req_sync;
        logic                                 ack_tog;
        logic [dram_burst_pkg::WORD_BITS-1:0] data;
        logic                                 oe;
        logic                                 last;
    } link_type;

    core_type                             s;
    core_type                             next_s;
    link_type                             lnk;
    link_type                             next_lnk;
    logic                                 fill_valid;
    logic                                 fill_ready;
    logic                                 fill_last;
    logic [dram_burst_pkg::LINK_BITS-1:0] fill_data;
    logic                                 drain_valid;
    logic                                 drain_ready;
    logic [dram_burst_pkg::LINK_BITS-1:0] drain_data;
    logic [2:0]                           cmd;

    // full burst when the field says so, or on the fly with the select bit high
    function automatic logic burst_is_full(input logic [1:0] field, input logic sel);
        return (field == dram_burst_pkg::BURST_FIELD_FULL) ||
               ((field == dram_burst_pkg::BURST_FIELD_FLY) && sel);
    endfunction

    // storage index from bank, low column bits and beat offset, wrapping inside the eight-beat block
    function automatic logic [dram_burst_pkg::MEM_BITS-1:0] mem_index(
        input logic [dram_burst_pkg::BANK_BITS-1:0]   bank,
        input logic [dram_burst_pkg::COLUMN_BITS-1:0] column,
        input logic [2:0]                             beat
    );
        return {bank, 3'(column[2:0] + beat)};
    endfunction

    assign cmd         = i_cmd_valid ? i_cmd : dram_burst_pkg::CMD_NOP;
    assign fill_valid  = (s.phase == dram_burst_pkg::PH_READ_BURST);
    assign fill_last   = (s.word == (s.full ? dram_burst_pkg::LAST_WORD_FULL : dram_burst_pkg::LAST_WORD_CHOP));
    // each word carries two beats, the earlier one in the low byte
    assign fill_data   = {fill_last,
                          s.mem[mem_index(s.bank, s.column, {s.word, 1'b1})],
                          s.mem[mem_index(s.bank, s.column, {s.word, 1'b0})]};
    // a new word may cross only when the previous toggle has come back
    assign drain_ready = (s.req_tog == s.ack_sync);

    // read words wait here; a slow link stalls the burst engine through fill_ready
    dram_word_fifo #(
        .WIDTH (dram_burst_pkg::LINK_BITS),
        .DEPTH (dram_burst_pkg::FIFO_DEPTH)
    ) read_fifo (
        .i_clk         (i_clk),
        .i_rst         (i_rst),
        .i_fill_valid  (fill_valid),
        .o_fill_ready  (fill_ready),
        .i_fill_data   (fill_data),
        .o_drain_valid (drain_valid),
        .i_drain_ready (drain_ready),
        .o_drain_data  (drain_data)
    );

    // bank state, command decode and the burst engine
    always_comb begin
        next_s = s;
        next_s.refused = 1'b0;
        for (int b = 0; b < dram_burst_pkg::NUM_BANKS; b++) begin
            if (s.pre_cnt[b] != '0) begin
                next_s.pre_cnt[b] = s.pre_cnt[b] - 1'b1;
            end
        end
        case (s.phase)
            dram_burst_pkg::PH_READ_WAIT: begin
                next_s.lat = s.lat - 1'b1;
                if (s.lat <= dram_burst_pkg::LAT_BITS'(1)) begin
                    next_s.phase = dram_burst_pkg::PH_READ_BURST;
                end
            end
            dram_burst_pkg::PH_READ_BURST: begin
                if (fill_ready) begin
                    next_s.word = s.word + 1'b1;
                    if (fill_last) begin
                        next_s.phase = dram_burst_pkg::PH_IDLE;
                        next_s.word  = '0;
                        if (s.auto_pre) begin
                            next_s.open[s.bank]    = 1'b0;
                            next_s.pre_cnt[s.bank] = dram_burst_pkg::ROW_PRECHARGE_CYCLES;
                        end
                    end
                end
            end
            dram_burst_pkg::PH_WRITE_BURST: begin
                if (i_wdata_valid) begin
                    // a violated word lands inverted in its own two beat locations only
                    next_s.mem[mem_index(s.bank, s.column, {s.word, 1'b0})] =
                        i_wdata[7:0] ^ {8{i_wdata_violation}};
                    next_s.mem[mem_index(s.bank, s.column, {s.word, 1'b1})] =
                        i_wdata[15:8] ^ {8{i_wdata_violation}};
                    next_s.word = s.word + 1'b1;
                    if (s.word == (s.full ? dram_burst_pkg::LAST_WORD_FULL : dram_burst_pkg::LAST_WORD_CHOP)) begin
                        next_s.phase = dram_burst_pkg::PH_IDLE;
                        next_s.word  = '0;
                        if (s.auto_pre) begin
                            next_s.open[s.bank]    = 1'b0;
                            next_s.pre_cnt[s.bank] = dram_burst_pkg::ROW_PRECHARGE_CYCLES;
                        end
                    end
                end
            end
            default: begin
            end
        endcase
        case (cmd)
            dram_burst_pkg::CMD_ACTIVATE: begin
                // an open or still precharging bank keeps its row
                if (!s.open[i_bank] && s.pre_cnt[i_bank] == '0) begin
                    next_s.open[i_bank] = 1'b1;
                end else begin
                    next_s.refused = 1'b1;
                end
            end
            dram_burst_pkg::CMD_PRECHARGE: begin
                // taken on idle banks too; the timer restarts on every one
                for (int b = 0; b < dram_burst_pkg::NUM_BANKS; b++) begin
                    if (i_addr[dram_burst_pkg::AUTO_PRECHARGE_BIT] || b == int'(i_bank)) begin
                        next_s.open[b]    = 1'b0;
                        next_s.pre_cnt[b] = dram_burst_pkg::ROW_PRECHARGE_CYCLES;
                    end
                end
            end
            dram_burst_pkg::CMD_READ, dram_burst_pkg::CMD_WRITE: begin
                // only one burst in flight, so another bank never cuts a transfer short
                if (s.phase == dram_burst_pkg::PH_IDLE && s.open[i_bank]) begin
                    next_s.bank     = i_bank;
                    next_s.column   = i_addr[dram_burst_pkg::COLUMN_BITS-1:0];
                    next_s.full     = burst_is_full(i_mode_burst_field,
                                                    i_addr[dram_burst_pkg::BURST_SELECT_ADDRESS_BIT]);
                    next_s.auto_pre = i_addr[dram_burst_pkg::AUTO_PRECHARGE_BIT];
                    next_s.word     = '0;
                    next_s.rl       = 6'(i_additive_latency) + 6'(i_cas_latency);
                    next_s.lat      = next_s.rl - 1'b1;
                    if (cmd == dram_burst_pkg::CMD_WRITE) begin
                        next_s.phase = dram_burst_pkg::PH_WRITE_BURST;
                    end else if (next_s.rl <= dram_burst_pkg::LAT_BITS'(1)) begin
                        next_s.phase = dram_burst_pkg::PH_READ_BURST;
                    end else begin
                        next_s.phase = dram_burst_pkg::PH_READ_WAIT;
                    end
                end else begin
                    next_s.refused = 1'b1;
                end
            end
            default: begin
            end
        endcase
        for (int b = 0; b < dram_burst_pkg::NUM_BANKS; b++) begin
            next_s.pre_busy[b] = (next_s.pre_cnt[b] != '0);
        end
        // the word register holds steady while its toggle is in flight
        if (drain_valid && drain_ready) begin
            next_s.xfer    = drain_data;
            next_s.req_tog = ~s.req_tog;
        end
        next_s.ack_meta = lnk.ack_tog;
        next_s.ack_sync = s.ack_meta;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s       <= '0;
            s.phase <= dram_burst_pkg::PH_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // link side: reset and request toggle each pass two flops before use
    always_comb begin
        next_lnk          = lnk;
        next_lnk.rst_meta = i_rst;
        next_lnk.rst_sync = lnk.rst_meta;
        next_lnk.req_meta = s.req_tog;
        next_lnk.req_sync = lnk.req_meta;
        next_lnk.oe       = 1'b0;
        next_lnk.last     = 1'b0;
        if (lnk.rst_sync) begin
            next_lnk.ack_tog = 1'b0;
            next_lnk.data    = '0;
        end else if (lnk.req_sync != lnk.ack_tog) begin
            next_lnk.data    = s.xfer[dram_burst_pkg::WORD_BITS-1:0];
            next_lnk.oe      = 1'b1;
            next_lnk.last    = s.xfer[dram_burst_pkg::WORD_BITS];
            next_lnk.ack_tog = lnk.req_sync;
        end
    end

    always_ff @(posedge i_link_clk) begin
        lnk <= next_lnk;
    end

    assign o_write_ready      = (s.phase == dram_burst_pkg::PH_WRITE_BURST);
    assign o_cmd_refused      = s.refused;
    assign o_bank_open        = s.open;
    assign o_bank_precharging = s.pre_busy;
    assign o_link_data        = lnk.data;
    assign o_link_strobe_oe   = lnk.oe;
    assign o_link_last        = lnk.last;

    // helper: cycles since the last read command seen while the engine was idle, taken or refused
    logic [dram_burst_pkg::LAT_BITS-1:0] since_read;
    always_ff @(posedge i_clk) begin
        if (i_rst || (cmd == dram_burst_pkg::CMD_READ && s.phase == dram_burst_pkg::PH_IDLE)) begin
            since_read <= '0;
        end else if (since_read != '1) begin
            since_read <= since_read + 1'b1;
        end
    end

    AST_PRECHARGE_ONE_BANK: assert property (@(posedge i_clk) disable iff (i_rst)
        (cmd == dram_burst_pkg::CMD_PRECHARGE && !i_addr[dram_burst_pkg::AUTO_PRECHARGE_BIT])
        |=> !o_bank_open[$past(i_bank)] && o_bank_precharging[$past(i_bank)])
        else $error("precharge did not close its bank");
    AST_PRECHARGE_ALL_BANKS: assert property (@(posedge i_clk) disable iff (i_rst)
        (cmd == dram_burst_pkg::CMD_PRECHARGE && i_addr[dram_burst_pkg::AUTO_PRECHARGE_BIT])
        |=> o_bank_open == '0 && o_bank_precharging == '1)
        else $error("precharge all left a bank open");
    AST_PRECHARGE_NEVER_REFUSED: assert property (@(posedge i_clk) disable iff (i_rst)
        cmd == dram_burst_pkg::CMD_PRECHARGE |=> !o_cmd_refused)
        else $error("precharge was refused");
    AST_PRECHARGE_FROM_LAST: assert property (@(posedge i_clk) disable iff (i_rst)
        (cmd == dram_burst_pkg::CMD_PRECHARGE && !i_addr[dram_burst_pkg::AUTO_PRECHARGE_BIT])
        |=> s.pre_cnt[$past(i_bank)] == dram_burst_pkg::ROW_PRECHARGE_CYCLES)
        else $error("precharge timer not restarted");
    AST_ROW_STAYS_OPEN: assert property (@(posedge i_clk) disable iff (i_rst)
        (cmd == dram_burst_pkg::CMD_ACTIVATE && o_bank_open[i_bank]) |=> o_cmd_refused && o_bank_open[$past(i_bank)])
        else $error("activate to an open bank was taken");
    AST_OTHER_BANK_TAKEN: assert property (@(posedge i_clk) disable iff (i_rst)
        ((cmd == dram_burst_pkg::CMD_READ || cmd == dram_burst_pkg::CMD_WRITE) && s.phase == dram_burst_pkg::PH_IDLE
         && o_bank_open[i_bank] && o_bank_precharging != '0) |=> !o_cmd_refused)
        else $error("access refused during another bank's precharge");
    AST_BURST_LENGTH: assert property (@(posedge i_clk) disable iff (i_rst)
        ((cmd == dram_burst_pkg::CMD_READ || cmd == dram_burst_pkg::CMD_WRITE) && s.phase == dram_burst_pkg::PH_IDLE
         && o_bank_open[i_bank])
        |=> s.full == ($past(i_mode_burst_field) == 2'h0 ||
                       ($past(i_mode_burst_field) == 2'h1 && $past(i_addr[12]))) && s.column == $past(i_addr[9:0]))
        else $error("burst length or column decoded wrongly");
    AST_CHOP_ENDS_EARLY: assert property (@(posedge i_clk) disable iff (i_rst)
        (fill_valid && fill_ready && fill_last) |-> s.word == (s.full ? 2'h3 : 2'h1) ##1 !fill_valid)
        else $error("burst moved the wrong number of words");
    AST_READ_LATENCY: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(fill_valid) |-> since_read == ((s.rl <= 6'h01) ? 6'h00 : s.rl - 6'h01))
        else $error("first read word at wrong latency");
    AST_VIOLATION_CONTAINED: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_write_ready && i_wdata_valid && i_wdata_violation && cmd == dram_burst_pkg::CMD_NOP && !fill_last)
        |=> o_bank_open == $past(o_bank_open) && !o_cmd_refused)
        else $error("write violation disturbed other state");
endmodule // dram_burst_core

// ==== include/dram_burst_pkg.sv ====
// shared constants and types for the precharge and burst select block
package dram_burst_pkg;
    // command codes on the command port
    localparam logic [2:0] CMD_NOP       = 3'h0;
    localparam logic [2:0] CMD_ACTIVATE  = 3'h1;
    localparam logic [2:0] CMD_READ      = 3'h2;
    localparam logic [2:0] CMD_WRITE     = 3'h3;
    localparam logic [2:0] CMD_PRECHARGE = 3'h4;
    localparam int NUM_BANKS    = 8;
    localparam int BANK_BITS    = 3;
    localparam int ADDR_BITS    = 14;
    localparam int COLUMN_BITS  = 10;
    localparam int BEAT_BITS    = 8;
    localparam int WORD_BITS    = 16;
    localparam int LINK_BITS    = 17;
    localparam int MEM_WORDS    = 64;
    localparam int MEM_BITS     = 6;
    localparam int LAT_BITS     = 6;
    localparam int PRE_BITS     = 4;
    localparam int FIFO_DEPTH   = 8;
    // address bit positions
    localparam int BURST_SELECT_ADDRESS_BIT = 12;
    localparam int AUTO_PRECHARGE_BIT       = 10;
    // burst length field of mode_register_zero
    localparam logic [1:0] BURST_FIELD_FULL  = 2'h0;
    localparam logic [1:0] BURST_FIELD_FLY   = 2'h1;
    // last word index (two beats per word) of each burst kind
    localparam logic [1:0] LAST_WORD_FULL = 2'h3;
    localparam logic [1:0] LAST_WORD_CHOP = 2'h1;
    // row_precharge_time, rounded up to whole cycles, at least one
    localparam int CLOCK_PERIOD_PS       = 25000;
    localparam int ROW_PRECHARGE_TIME_PS = 50000;
    localparam int ROW_PRECHARGE_CALC    = (ROW_PRECHARGE_TIME_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam logic [PRE_BITS-1:0] ROW_PRECHARGE_CYCLES =
        PRE_BITS'((ROW_PRECHARGE_CALC < 1) ? 1 : ROW_PRECHARGE_CALC);
    // one-hot phases of the burst engine
    typedef enum logic [3:0] {
        PH_IDLE        = 4'h1,
        PH_READ_WAIT   = 4'h2,
        PH_READ_BURST  = 4'h4,
        PH_WRITE_BURST = 4'h8
    } phase_type;
endpackage

// ==== testbench/link_receiver.sv ====
// link side receiver model that records every word offered on the link
`timescale 1ns/1ps
module link_receiver (
    input  wire logic                                 i_link_clk,
    input  wire logic [dram_burst_pkg::WORD_BITS-1:0] i_data,
    input  wire logic                                 i_strobe_oe,
    input  wire logic                                 i_last
);
    logic [dram_burst_pkg::WORD_BITS:0] words[$];
    // take each word at the link edge that sees the strobe enable high
    always @(posedge i_link_clk) begin
        if (i_strobe_oe === 1'b1) begin
            words.push_back({i_last, i_data});
        end
    end
endmodule // link_receiver

// ==== testbench/testbench.sv ====
// self-checking bench for the precharge and burst select core
`timescale 1ns/1ps
module testbench;
    logic        i_clk = 1'b0, i_link_clk = 1'b0, i_rst = 1'b1, cv = 1'b0, wv = 1'b0, wbad = 1'b0;
    logic [2:0]  cmd = 3'h0, bank = 3'h0;
    logic [13:0] addr = 14'h0000;
    logic [1:0]  mode = 2'h1;
    logic [15:0] wdata = 16'h0000, ldata;
    logic [7:0]  bopen, bpre;
    logic        wready, refd, loe, llast;
    int          err_total = 0, n_compared = 0, cycles = 0;
    dram_burst_core dram_burst_core_i (.i_clk(i_clk), .i_rst(i_rst), .i_link_clk(i_link_clk), .i_cmd_valid(cv),
        .i_cmd(cmd), .i_bank(bank), .i_addr(addr), .i_mode_burst_field(mode), .i_additive_latency(5'h00),
        .i_cas_latency(5'h05), .i_wdata_valid(wv), .i_wdata(wdata), .i_wdata_violation(wbad),
        .o_write_ready(wready), .o_cmd_refused(refd), .o_bank_open(bopen), .o_bank_precharging(bpre),
        .o_link_data(ldata), .o_link_strobe_oe(loe), .o_link_last(llast));
    link_receiver link_receiver_i (.i_link_clk(i_link_clk), .i_data(ldata), .i_strobe_oe(loe), .i_last(llast));
    // core clock, and a link clock offset so the two never line up
    always #12.5 i_clk = ~i_clk;
    initial #7 forever #32 i_link_clk = ~i_link_clk;
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one-cycle command strobe; the refusal pulse may land in either of the next two cycles
    task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a, input logic exp);
        logic r;
        @(posedge i_clk);
        cv <= 1'b1; cmd <= c; bank <= b; addr <= a;
        @(posedge i_clk);
        cv <= 1'b0;
        @(negedge i_clk) r = refd;
        @(negedge i_clk) r = r | refd;
        check(17'(r), 17'(exp));
    endtask
    task automatic write_words(input int n, input logic [15:0] base, input int bad);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            wv <= 1'b1; wdata <= base + 16'(k); wbad <= (k == bad);
        end
        @(posedge i_clk);
        wv <= 1'b0; wbad <= 1'b0;
    endtask
    // waits long enough for a whole full burst, so extra words past a chop also show up
    task automatic read_check(input logic [2:0] b, input logic [13:0] a, input int n, input logic [15:0] base, input int bad);
        logic [15:0] w;
        issue(dram_burst_pkg::CMD_READ, b, a, 1'b0);
        repeat (120) @(posedge i_clk);
        check(17'(link_receiver_i.words.size()), 17'(n));
        for (int k = 0; k < n && link_receiver_i.words.size() > 0; k++) begin
            w = base + 16'(k);
            check(link_receiver_i.words.pop_front(), {k == n - 1, (k == bad) ? ~w : w});
        end
        link_receiver_i.words.delete();
    endtask
    task automatic scen_precharge();
        issue(dram_burst_pkg::CMD_ACTIVATE, 3'h0, 14'h0000, 1'b0);
        issue(dram_burst_pkg::CMD_ACTIVATE, 3'h3, 14'h0000, 1'b0);
        issue(dram_burst_pkg::CMD_ACTIVATE, 3'h0, 14'h0000, 1'b1);
        check(17'(bopen), 17'h00009);
        issue(dram_burst_pkg::CMD_PRECHARGE, 3'h0, 14'h0000, 1'b0);
        check(17'(bopen), 17'h00008);
        issue(dram_burst_pkg::CMD_PRECHARGE, 3'h0, 14'h0000, 1'b0);
        issue(dram_burst_pkg::CMD_PRECHARGE, 3'h5, 14'h0400, 1'b0);
        check(17'(bopen), 17'h00000);
        issue(dram_burst_pkg::CMD_READ, 3'h0, 14'h0000, 1'b1);
        repeat (8) @(posedge i_clk);
        check(17'(bpre), 17'h00000);
    endtask
    task automatic scen_chop();
        issue(dram_burst_pkg::CMD_ACTIVATE, 3'h1, 14'h0000, 1'b0);
        issue(dram_burst_pkg::CMD_WRITE, 3'h1, 14'h0000, 1'b0);
        write_words(2, 16'h1100, 9);
        read_check(3'h1, 14'h0000, 2, 16'h1100, 9);
    endtask
    // full write with one broken word, then a read that auto precharges, after which bank one is still open and is read again
    task automatic scen_full();
        issue(dram_burst_pkg::CMD_ACTIVATE, 3'h2, 14'h0000, 1'b0);
        issue(dram_burst_pkg::CMD_WRITE, 3'h2, 14'h1000, 1'b0);
        write_words(4, 16'h2200, 2);
        @(posedge i_clk) mode <= 2'h0;
        read_check(3'h2, 14'h0400, 4, 16'h2200, 2);
        @(posedge i_clk) mode <= 2'h1;
        check(17'(bopen), 17'h00002);
        read_check(3'h1, 14'h0000, 2, 16'h1100, 9);
    endtask
    // cut a hung run short
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        scen_precharge();
        scen_chop();
        scen_full();
        complete_run();
    end
endmodule // testbench
